//--- rtl/uart_mls_pkg.sv
package uart_mls_pkg;

  // host register offsets
  localparam logic [2:0] ADDR_RX_TX = 3'h0;
  localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;

  // modem_control fields
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_RING = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_XON_ANY = 5;
  localparam int MC_IR = 6;
  localparam int MC_PRESCALE = 7;
  // bits 7..5 only writable with the enhanced feature enable
  localparam logic [7:0] MC_ENH_MASK = 8'hE0;

  // line_status fields
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_TX_IDLE = 6;
  localparam int LS_FIFO_ERR = 7;

  // modem_status fields: deltas low, line states high
  localparam int MS_DELTA_LSB = 0;
  localparam int MS_STATE_LSB = 4;

  // reset values
  localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'hFF;

  // prescaler: divide by four gives an enable every fourth cycle
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // two-entry receive store
  localparam logic [1:0] RX_DEPTH = 2'h2;

  // one received character with its error tags
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
    logic [7:0] data;
  } rx_char_s;

  // modem lines, order matches modem_status bits 7..4
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_lines_s;

endpackage

//--- rtl/uart_modem_line_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

module uart_modem_line_status_regs
  import uart_mls_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // host register port
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // feature settings from neighbouring registers
  input wire logic enh_enable,
  input wire logic auto_rts_en,
  input wire logic auto_cts_en,
  input wire logic rs485_en,
  input wire logic auto_rts_n,
  input wire logic rs485_dir_n,
  input wire logic irq_modem_en,
  input wire logic sw_flow_en,
  input wire logic uart_irq,
  // modem pins
  input wire modem_lines_s modem_n,
  output logic dtr_n,
  output logic rts_n,
  output logic user_output_two_n,
  output logic int_out,
  output logic int_oe_n,
  output logic modem_irq,
  // receiver side
  input wire logic rx_char_valid,
  input wire rx_char_s rx_char,
  input wire logic rx_char_is_flow,
  output logic rx_char_ready,
  output logic xon_any_resume,
  // transmitter side
  input wire logic tx_taken,
  input wire logic tx_shift_busy,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  output logic tx_allowed,
  // serial routing
  input wire logic tx_serial,
  input wire logic ir_tx,
  input wire logic rx_pin,
  input wire logic ir_rx,
  output logic tx_pin,
  output logic rx_serial,
  output logic ir_enable,
  output logic loopback,
  output logic baud_clk_en
);

  // address match, shared by read and write decode
  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction
  logic [7:0] modem_control;
  logic [7:0] scratch;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic [3:0] delta;
  logic [3:0] state_q;
  logic state_seen;
  logic overrun;
  logic brk_run;
  logic thr_full;
  logic [1:0] presc_cnt;
  rx_char_s mem [0:1];
  logic wr_ptr, rd_ptr;
  logic [1:0] count, next_count;
  logic [3:0] line_state;
  logic [3:0] delta_set;
  logic wr_data;
  logic rd_data;
  logic rd_msr, rd_lsr;
  logic take;
  logic push;
  logic pop;
  logic drop_flow;
  logic drop_brk;
  logic err_any;
  rx_char_s head;

  // strobe decode
  assign wr_data = wr_stb && hit(addr, ADDR_RX_TX);
  assign rd_data = rd_stb && hit(addr, ADDR_RX_TX);
  assign rd_msr = rd_stb && hit(addr, ADDR_MODEM_STATUS);
  assign rd_lsr = rd_stb && hit(addr, ADDR_LINE_STATUS);

  // modem control; enhanced bits keep their value unless unlocked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      modem_control <= MODEM_CONTROL_RESET;
    end else if (wr_stb && hit(addr, ADDR_MODEM_CONTROL)) begin
      if (enh_enable) begin
        modem_control <= wdata;
      end else begin
        modem_control <= (modem_control & MC_ENH_MASK) | (wdata & ~MC_ENH_MASK);
      end
    end
  end

  // scratch holds its value; only a host write or reset touches it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scratch <= SCRATCH_RESET;
    end else if (wr_stb && hit(addr, ADDR_SCRATCH)) begin
      scratch <= wdata;
    end
  end

  // modem pin drivers; loopback parks terminal-ready and request-to-send inactive
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      user_output_two_n <= 1'b1;
      int_oe_n <= 1'b1;
      int_out <= 1'b0;
      loopback <= 1'b0;
    end else begin
      dtr_n <= modem_control[MC_LOOP] || !modem_control[MC_DTR];
      if (modem_control[MC_LOOP]) begin
        rts_n <= 1'b1;
      end else if (rs485_en) begin
        rts_n <= rs485_dir_n;
      end else if (auto_rts_en) begin
        rts_n <= auto_rts_n;
      end else begin
        rts_n <= !modem_control[MC_RTS];
      end
      user_output_two_n <= !modem_control[MC_OUT2];
      int_oe_n <= !modem_control[MC_OUT2];
      int_out <= uart_irq || (irq_modem_en && (delta != 4'h0));
      loopback <= modem_control[MC_LOOP];
    end
  end

  // serial routing: loopback, infrared or plain pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_pin <= 1'b1;
      rx_serial <= 1'b1;
      ir_enable <= 1'b0;
    end else begin
      ir_enable <= modem_control[MC_IR];
      if (modem_control[MC_LOOP]) begin
        tx_pin <= !modem_control[MC_IR];
        rx_serial <= tx_serial;
      end else if (modem_control[MC_IR]) begin
        tx_pin <= ir_tx;
        rx_serial <= ir_rx;
      end else begin
        tx_pin <= tx_serial;
        rx_serial <= rx_pin;
      end
    end
  end

  // prescaler enable; held low counter keeps divide-by-one free running
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      presc_cnt <= 2'h0;
      baud_clk_en <= 1'b0;
    end else if (modem_control[MC_PRESCALE]) begin
      presc_cnt <= presc_cnt + 2'h1;
      baud_clk_en <= (presc_cnt == PRESCALE_LAST);
    end else begin
      presc_cnt <= 2'h0;
      baud_clk_en <= 1'b1;
    end
  end

  // line states, either inverted pins or looped controls
  always_comb begin
    if (modem_control[MC_LOOP]) begin
      line_state = {modem_control[MC_OUT2], modem_control[MC_RING],
                    modem_control[MC_DTR], modem_control[MC_RTS]};
    end else begin
      line_state = ~modem_n;
    end
  end

  // ring delta only when ring state falls, the end of ringing
  assign delta_set = state_seen ?
    {line_state[3] ^ state_q[3], state_q[2] && !line_state[2],
     line_state[1] ^ state_q[1], line_state[0] ^ state_q[0]} : 4'h0;

  // deltas: a change in the read cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      delta <= 4'h0;
      state_q <= 4'h0;
      state_seen <= 1'b0;
      modem_irq <= 1'b0;
    end else begin
      state_q <= line_state;
      state_seen <= 1'b1;
      delta <= (delta & ~{4{rd_msr}}) | delta_set;
      modem_irq <= irq_modem_en && (((delta & ~{4{rd_msr}}) | delta_set) != 4'h0);
    end
  end
  assign modem_status = {line_state, delta}; // states high, deltas low

  // transmit holding flag; a new byte outranks the shifter taking the old one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      thr_full <= 1'b0;
      tx_byte <= 8'h00;
      tx_byte_valid <= 1'b0;
    end else begin
      if (wr_data) begin
        thr_full <= 1'b1;
        tx_byte <= wdata;
      end else if (tx_taken) begin
        thr_full <= 1'b0;
      end
      tx_byte_valid <= wr_data || (thr_full && !tx_taken);
    end
  end

  // auto clear-to-send only changes while no character is shifting
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_allowed <= 1'b1;
    end else if (!tx_shift_busy) begin
      tx_allowed <= !auto_cts_en || line_state[0];
    end
  end

  // receive admission: flow characters and repeated breaks are filtered
  assign drop_flow = sw_flow_en && rx_char_is_flow;
  assign drop_brk = rx_char.brk && brk_run;
  assign take = rx_char_valid && !drop_flow && !drop_brk;
  assign push = take && rx_char_ready;
  assign pop = rd_data && (count != 2'h0);
  assign next_count = 2'(count + {1'b0, push} - {1'b0, pop});

  // xon-any resumes on any character, even one that is filtered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xon_any_resume <= 1'b0;
    end else begin
      xon_any_resume <= rx_char_valid && modem_control[MC_XON_ANY];
    end
  end

  // break run ends with the first ordinary character
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      brk_run <= 1'b0;
    end else if (rx_char_valid && !drop_flow) begin
      brk_run <= rx_char.brk;
    end
  end

  // two-entry receive store; when full, the newest character is lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      rx_char_ready <= 1'b1;
    end else begin
      if (push) begin
        mem[wr_ptr] <= rx_char;
        wr_ptr <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      count <= next_count;
      rx_char_ready <= (next_count != RX_DEPTH);
    end
  end

  // overrun sticks until line status is read; a new overrun wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      overrun <= 1'b0;
    end else if (take && !rx_char_ready) begin
      overrun <= 1'b1;
    end else if (rd_lsr) begin
      overrun <= 1'b0;
    end
  end

  // head tags and the store-wide error summary
  always_comb begin
    head = '0;
    err_any = 1'b0;
    if (count != 2'h0) begin
      head = mem[rd_ptr];
      err_any = mem[rd_ptr].brk || mem[rd_ptr].frm || mem[rd_ptr].par;
    end
    if (count == RX_DEPTH) begin
      err_any = err_any || mem[!rd_ptr].brk || mem[!rd_ptr].frm || mem[!rd_ptr].par;
    end
  end

  // status byte as the host reads it
  always_comb begin
    line_status = 8'h00;
    line_status[LS_DATA_READY] = (count != 2'h0);
    line_status[LS_OVERRUN] = overrun;
    line_status[LS_PARITY] = head.par;
    line_status[LS_FRAMING] = head.frm;
    line_status[LS_BREAK] = head.brk;
    line_status[LS_THR_EMPTY] = !thr_full;
    line_status[LS_TX_IDLE] = !thr_full && !tx_shift_busy;
    line_status[LS_FIFO_ERR] = err_any;
  end

  // read data is registered; unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      unique case (addr)
        ADDR_RX_TX: rdata <= head.data;
        ADDR_MODEM_CONTROL: rdata <= modem_control;
        ADDR_LINE_STATUS: rdata <= line_status;
        ADDR_MODEM_STATUS: rdata <= modem_status;
        ADDR_SCRATCH: rdata <= scratch;
        default: rdata <= 8'h00;
      endcase
    end
  end

  a_dtr_drive: assert property (@(posedge clk_sys) disable iff (rst)
    !modem_control[MC_LOOP] |=> dtr_n == !$past(modem_control[MC_DTR]))
    else $error("terminal-ready pin does not follow control bit");
  a_rts_plain: assert property (@(posedge clk_sys) disable iff (rst)
    !modem_control[MC_LOOP] && !rs485_en && !auto_rts_en
    |=> rts_n == !$past(modem_control[MC_RTS]))
    else $error("request-to-send pin does not follow control bit");
  a_rts_rs485: assert property (@(posedge clk_sys) disable iff (rst)
    !modem_control[MC_LOOP] && rs485_en |=> rts_n == $past(rs485_dir_n))
    else $error("request-to-send ignores direction control");
  a_out2_int_en: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 (user_output_two_n == int_oe_n) && (int_oe_n == !$past(modem_control[MC_OUT2])))
    else $error("output two or interrupt enable wrong");
  a_loop_states: assert property (@(posedge clk_sys) disable iff (rst)
    modem_control[MC_LOOP] |-> modem_status[7:4] == {modem_control[3:2],
      modem_control[MC_DTR], modem_control[MC_RTS]})
    else $error("looped line states wrong");
  a_prescale_gap: assert property (@(posedge clk_sys) disable iff (rst)
    baud_clk_en && modem_control[MC_PRESCALE] ##1 modem_control[MC_PRESCALE]
    |-> !baud_clk_en)
    else $error("prescaler enable too frequent");
  a_overrun_set: assert property (@(posedge clk_sys) disable iff (rst)
    take && !rx_char_ready |=> overrun && $stable(count) || count < $past(count))
    else $error("overrun not flagged or character stored");
  a_msr_clear: assert property (@(posedge clk_sys) disable iff (rst)
    rd_msr && delta_set == 4'h0 |=> delta == 4'h0)
    else $error("deltas not cleared by read");
  a_thre_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_data |=> !line_status[LS_THR_EMPTY] && !line_status[LS_TX_IDLE])
    else $error("holding empty still set after write");
  a_scratch_store: assert property (@(posedge clk_sys) disable iff (rst)
    wr_stb && hit(addr, ADDR_SCRATCH) |=> scratch == $past(wdata))
    else $error("scratch did not store");
  a_cts_hold: assert property (@(posedge clk_sys) disable iff (rst)
    tx_shift_busy |=> $stable(tx_allowed))
    else $error("flow gate changed mid character");

endmodule // uart_modem_line_status_regs
`default_nettype wire

//--- verif/uart_modem_partner.sv
`timescale 1ns/1ps
`default_nettype none
module uart_modem_partner
  import uart_mls_pkg::*;
#(
  parameter int SHIFT_CYC = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // transmitter handshake
  input wire logic tx_byte_valid,
  input wire logic tx_allowed,
  input wire logic hold_off,
  output logic tx_taken,
  output logic tx_shift_busy,
  // modem pins, active low
  output var modem_lines_s modem_n
);
  int cnt = 0;
  // lines start deasserted, as an idle modem leaves them
  // shifter outputs settle at the first falling edge, inside reset
  initial begin
    modem_n = 4'hF;
  end
  // the remote end moves its lines between clock edges only
  task automatic set_lines(input logic [3:0] v);
    @(negedge clk_sys);
    modem_n = v;
  endtask
  // shifter: one byte when idle and allowed, then busy for a frame
  always @(negedge clk_sys) begin
    tx_taken <= 1'b0;
    if (rst) begin
      cnt <= 0;
      tx_shift_busy <= 1'b0;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      tx_shift_busy <= (cnt != 1);
    end else if (tx_byte_valid && tx_allowed && !hold_off) begin
      tx_taken <= 1'b1;
      tx_shift_busy <= 1'b1;
      cnt <= SHIFT_CYC;
    end
  end
endmodule // uart_modem_partner
`default_nettype wire

//--- verif/tb_uart_modem_line_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_uart_modem_line_status_regs
  import uart_mls_pkg::*;
;
  typedef struct packed {
    logic [7:0] mc;
    logic [7:0] pins;
  } row_s;
  // pins: dtr_n rts_n out2_n oe_n loopback ir tx_pin rx_serial
  localparam row_s ROWS [9] = '{'{8'h00, 8'hF2}, '{8'h01, 8'h72}, '{8'h02, 8'hB2},
    '{8'h04, 8'hF2}, '{8'h08, 8'hC2}, '{8'h10, 8'hFB}, '{8'h40, 8'hF5},
    '{8'h50, 8'hFD}, '{8'h0B, 8'h02}};
  // lines driven, then modem_status expected
  localparam logic [11:0] MS_ROWS [3] = '{12'hA50, 12'hE14, 12'h4BA};
  logic clk_sys = 0, rst = 1, rd_stb = 0, wr_stb = 0, enh_enable = 1;
  logic auto_rts_en = 0, auto_cts_en = 0, rs485_en = 0, auto_rts_n = 1;
  logic rs485_dir_n = 1, irq_modem_en = 0, sw_flow_en = 0, uart_irq = 0;
  logic rx_char_valid = 0, rx_char_is_flow = 0, hold_off = 1;
  // serial lines tied: routing is still told apart by their levels
  logic tx_serial = 1, ir_tx = 0, rx_pin = 0, ir_rx = 1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  rx_char_s rx_char = '0;
  logic [7:0] rdata, tx_byte;
  logic dtr_n, rts_n, user_output_two_n, int_out, int_oe_n, modem_irq;
  logic rx_char_ready, xon_any_resume, tx_taken, tx_shift_busy, tx_byte_valid;
  logic tx_allowed, tx_pin, rx_serial, ir_enable, loopback, baud_clk_en;
  modem_lines_s modem_n;
  int errors = 0, n_tests = 0, k, n_resume = 0, nb;

  uart_modem_line_status_regs DUT (.clk_sys(clk_sys), .rst(rst), .rd_stb(rd_stb),
    .wr_stb(wr_stb), .addr(addr), .wdata(wdata), .rdata(rdata), .enh_enable(enh_enable),
    .auto_rts_en(auto_rts_en), .auto_cts_en(auto_cts_en), .rs485_en(rs485_en),
    .auto_rts_n(auto_rts_n), .rs485_dir_n(rs485_dir_n), .irq_modem_en(irq_modem_en),
    .sw_flow_en(sw_flow_en), .uart_irq(uart_irq), .modem_n(modem_n), .dtr_n(dtr_n),
    .rts_n(rts_n), .user_output_two_n(user_output_two_n), .int_out(int_out),
    .int_oe_n(int_oe_n), .modem_irq(modem_irq), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_char_is_flow(rx_char_is_flow), .rx_char_ready(rx_char_ready),
    .xon_any_resume(xon_any_resume), .tx_taken(tx_taken), .tx_shift_busy(tx_shift_busy),
    .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .tx_allowed(tx_allowed),
    .tx_serial(tx_serial), .ir_tx(ir_tx), .rx_pin(rx_pin), .ir_rx(ir_rx), .tx_pin(tx_pin),
    .rx_serial(rx_serial), .ir_enable(ir_enable), .loopback(loopback),
    .baud_clk_en(baud_clk_en));

  uart_modem_partner partner (.clk_sys(clk_sys), .rst(rst), .tx_byte_valid(tx_byte_valid),
    .tx_allowed(tx_allowed), .hold_off(hold_off), .tx_taken(tx_taken),
    .tx_shift_busy(tx_shift_busy), .modem_n(modem_n));

  // free-running system clock
  always #5 clk_sys = ~clk_sys;

  // a level here would count more than once
  always @(negedge clk_sys) begin
    if (xon_any_resume === 1'b1) n_resume++;
  end

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: pins got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    wr_stb = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_sys);
    wr_stb = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(negedge clk_sys);
    rd_stb = 1'b1;
    addr = a;
    @(negedge clk_sys);
    rd_stb = 1'b0;
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
    rd(a);
    n_tests++;
    if (rdata !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: reg %h got %h expected %h", $time, a, rdata, exp);
    end
  endtask

  task automatic push(input logic [10:0] c, input logic fl);
    @(negedge clk_sys);
    rx_char_valid = 1'b1;
    rx_char = rx_char_s'(c);
    rx_char_is_flow = fl;
    @(negedge clk_sys);
    rx_char_valid = 1'b0;
  endtask

  task automatic count_baud(input logic [7:0] exp);
    nb = 0;
    repeat (8) begin
      @(negedge clk_sys);
      if (baud_clk_en === 1'b1) nb++;
    end
    chk_pin(nb[7:0], exp);
  endtask

  task automatic summarize();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #200000;
    errors++;
    summarize();
  end

  // main sequence
  initial begin
    wait_n(12);
    rst = 1'b0;
    for (k = 0; k < 9; k++) begin
      wr(ADDR_MODEM_CONTROL, ROWS[k].mc);
      wait_n(2);
      chk_pin({dtr_n, rts_n, user_output_two_n, int_oe_n, loopback, ir_enable, tx_pin,
        rx_serial}, ROWS[k].pins);
      chk_reg(ADDR_MODEM_CONTROL, ROWS[k].mc);
    end
    // loopback: line states come from control bits
    wr(ADDR_MODEM_CONTROL, 8'h1F);
    rd(ADDR_MODEM_STATUS);
    chk_reg(ADDR_MODEM_STATUS, 8'hF0);
    wr(ADDR_MODEM_CONTROL, 8'h1A);
    rd(ADDR_MODEM_STATUS);
    chk_reg(ADDR_MODEM_STATUS, 8'h90);
    // change detection and interrupt
    wr(ADDR_MODEM_CONTROL, 8'h08);
    irq_modem_en = 1'b1;
    rd(ADDR_MODEM_STATUS);
    chk_reg(ADDR_MODEM_STATUS, 8'h00);
    partner.set_lines(4'hE);
    wait_n(3);
    chk_pin({6'h00, modem_irq, int_out}, 8'h03);
    chk_reg(ADDR_MODEM_STATUS, 8'h11);
    chk_reg(ADDR_MODEM_STATUS, 8'h10);
    wait_n(2);
    chk_pin({6'h00, modem_irq, int_out}, 8'h00);
    // other interrupt sources reach the interrupt pin too
    uart_irq = 1'b1;
    wait_n(2);
    chk_pin({6'h00, modem_irq, int_out}, 8'h01);
    uart_irq = 1'b0;
    for (k = 0; k < 3; k++) begin
      partner.set_lines(MS_ROWS[k][11:8]);
      wait_n(3);
      chk_reg(ADDR_MODEM_STATUS, MS_ROWS[k][7:0]);
    end
    // request-to-send overrides, direction control first
    // bit 3 cleared, as the alternate bus style would demand of the host
    wr(ADDR_MODEM_CONTROL, 8'h00);
    auto_rts_en = 1'b1;
    auto_rts_n = 1'b0;
    wait_n(2);
    chk_pin({7'h00, rts_n}, 8'h00);
    rs485_en = 1'b1;
    wait_n(2);
    chk_pin({7'h00, rts_n}, 8'h01);
    rs485_en = 1'b0;
    auto_rts_en = 1'b0;
    // auto clear-to-send holds the byte until the line is asserted
    auto_cts_en = 1'b1;
    partner.set_lines(4'h5);
    wait_n(3);
    chk_pin({7'h00, tx_allowed}, 8'h00);
    wr(ADDR_RX_TX, 8'hA5);
    hold_off = 1'b0;
    wait_n(5);
    chk_pin(tx_byte, 8'hA5);
    chk_reg(ADDR_LINE_STATUS, 8'h00);
    partner.set_lines(4'h4);
    wait_n(4);
    chk_reg(ADDR_LINE_STATUS, 8'h20);
    wait_n(14);
    chk_reg(ADDR_LINE_STATUS, 8'h60);
    // receive store: fill past two entries, then drain
    push(11'h111, 1'b0);
    push(11'h222, 1'b0);
    push(11'h033, 1'b0);
    chk_pin({7'h00, rx_char_ready}, 8'h00);
    chk_reg(ADDR_LINE_STATUS, 8'hE7);
    chk_reg(ADDR_RX_TX, 8'h11);
    chk_reg(ADDR_LINE_STATUS, 8'hE9);
    chk_reg(ADDR_RX_TX, 8'h22);
    chk_reg(ADDR_LINE_STATUS, 8'h60);
    chk_reg(ADDR_RX_TX, 8'h00);
    push(11'h400, 1'b0);
    push(11'h400, 1'b0);
    chk_reg(ADDR_LINE_STATUS, 8'hF1);
    chk_reg(ADDR_RX_TX, 8'h00);
    chk_reg(ADDR_LINE_STATUS, 8'h60);
    // any character resumes, flow characters are not stored
    wr(ADDR_MODEM_CONTROL, 8'h20);
    sw_flow_en = 1'b1;
    n_resume = 0;
    push(11'h011, 1'b1);
    wait_n(4);
    chk_pin(n_resume[7:0], 8'h01);
    chk_reg(ADDR_LINE_STATUS, 8'h60);
    push(11'h055, 1'b0);
    wait_n(4);
    chk_pin(n_resume[7:0], 8'h02);
    chk_reg(ADDR_RX_TX, 8'h55);
    // prescaler and the gate on the upper control bits
    wr(ADDR_MODEM_CONTROL, 8'h80);
    wait_n(2);
    count_baud(8'h02);
    wr(ADDR_MODEM_CONTROL, 8'h00);
    wait_n(2);
    count_baud(8'h08);
    enh_enable = 1'b0;
    wr(ADDR_MODEM_CONTROL, 8'hE0);
    chk_reg(ADDR_MODEM_CONTROL, 8'h00);
    // reset in mid-run restores defaults
    wr(ADDR_SCRATCH, 8'h5A);
    chk_reg(ADDR_SCRATCH, 8'h5A);
    wr(ADDR_MODEM_CONTROL, 8'h0B);
    rst = 1'b1;
    wait_n(2);
    rst = 1'b0;
    wait_n(2);
    chk_pin({dtr_n, rts_n, user_output_two_n, int_oe_n, rx_char_ready, tx_byte_valid,
      tx_allowed, int_out}, 8'hFA);
    chk_reg(ADDR_SCRATCH, 8'hFF);
    chk_reg(ADDR_MODEM_CONTROL, 8'h00);
    chk_reg(ADDR_LINE_STATUS, 8'h60);
    chk_reg(ADDR_MODEM_STATUS, 8'hB0);
    summarize();
  end
endmodule // tb_uart_modem_line_status_regs
`default_nettype wire
